// File: design/chan1_config_defines.vh
// constants for the channel 1 configuration register bank
// assumes: included by bare name from design files under design/
//
// What this block does
// - bit 7 of input setup picks microphone (0) or line (1) input kind
// - bits 6-5 pick differential, single-ended or pulse microphone source; 3 reserved
// - bit 4 picks AC (0) or DC (1) coupling, only with analog source
// - bits 3-2 pick 2.5k, 10k or 20k input impedance; 3 reserved
// - bit 1 of input setup is reserved, reads zero, host writes reset value
// - bit 0 enables range function chosen by bit 3 of mode register 108
// - gain code bits 7-1, 0.5 dB steps, 0 to 42 dB at 84; above reserved
// - gain bit 0 makes gain negative, down to -11 dB, only 10k/20k impedance
// - volume 0 mutes, 1 is -100 dB, 0.5 dB steps, 201 is 0 dB
// - trim bits 7-4, 0.1 dB steps, code 8 is 0 dB, -0.8 to 0.7 dB
// - trim bits 3-0 are reserved, read zero, host writes zeros
// - volume register resets to 0xC9, meaning 0 dB
`ifndef CHAN1_CONFIG_DEFINES_VH
`define CHAN1_CONFIG_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_INPUT_SETUP     8'h3c
`define OFS_ANALOG_GAIN     8'h3d
`define OFS_DIGITAL_VOLUME  8'h3e
`define OFS_GAIN_TRIM       8'h3f

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_INPUT_SETUP     8'h00
`define RST_ANALOG_GAIN     8'h00
`define RST_DIGITAL_VOLUME  8'hc9
`define RST_GAIN_TRIM       8'h80
`define MASK_INPUT_SETUP    8'hfd
`define MASK_ANALOG_GAIN    8'hff
`define MASK_DIGITAL_VOLUME 8'hff
`define MASK_GAIN_TRIM      8'hf0

// ----------------------------------------
// field positions
// ----------------------------------------
`define POS_INPUT_KIND      7
`define POS_SOURCE_HI       6
`define POS_SOURCE_LO       5
`define POS_COUPLING        4
`define POS_IMPEDANCE_HI    3
`define POS_IMPEDANCE_LO    2
`define POS_RANGE_ENABLE    0
`define POS_GAIN_HI         7
`define POS_GAIN_LO         1
`define POS_GAIN_NEGATIVE   0
`define POS_TRIM_HI         7
`define POS_TRIM_LO         4

// ----------------------------------------
// field codes and scale points
// ----------------------------------------
`define SRC_DIFFERENTIAL    2'h0
`define SRC_SINGLE_ENDED    2'h1
`define SRC_PULSE_MIC       2'h2
`define SRC_RESERVED        2'h3
`define IMP_2K5             2'h0
`define IMP_RESERVED        2'h3
`define GAIN_CODE_MAX       7'h54
`define GAIN_NEG_MAX_HALFDB 7'h16
`define VOLUME_ZERO_DB      9'h0c9
`define TRIM_ZERO_DB        5'h08

// ----------------------------------------
// control port
// ----------------------------------------
`define CTRL_DEVICE_ADDR    7'h4c

`endif

// File: design/chan1_field_decode.v
// registered decode of the channel 1 fields into datapath controls
// assumes: register values are stable flops in the clk_sys domain
`timescale 1ns/1ns
`include "chan1_config_defines.vh"

module chan1_field_decode (
    input  wire              clk_sys,
    input  wire              rstn,
    input  wire [7:0]        inputSetup,
    input  wire [7:0]        analogGain,
    input  wire [7:0]        digitalVolume,
    input  wire [7:0]        gainTrim,
    input  wire              rangeModeSelect,
    output reg               sourceAnalog,
    output reg               sourcePulseMic,
    output reg               sourceReserved,
    output reg               couplingDcActive,
    output reg               impedanceReserved,
    output reg               enhancerActive,
    output reg               levelControlActive,
    output reg signed [7:0]  gainHalfDb,
    output reg               gainCodeReserved,
    output reg               negativeGainIllegal,
    output reg               volumeMute,
    output reg signed [8:0]  volumeHalfDb,
    output reg signed [4:0]  trimTenthDb
);

    // ----------------------------------------
    // gain in half dB with clamping
    // ----------------------------------------
    function signed [7:0] gainValue;
        input [6:0] code;
        input       negative;
        reg   [6:0] mag;
        begin
            mag = (code > `GAIN_CODE_MAX) ? `GAIN_CODE_MAX : code;
            if (negative) begin
                if (mag > `GAIN_NEG_MAX_HALFDB) begin
                    mag = `GAIN_NEG_MAX_HALFDB;
                end
                gainValue = -$signed({1'b0, mag});
            end else begin
                gainValue = $signed({1'b0, mag});
            end
        end
    endfunction

    wire [1:0] source    = inputSetup[`POS_SOURCE_HI:`POS_SOURCE_LO];
    wire [1:0] impedance = inputSetup[`POS_IMPEDANCE_HI:`POS_IMPEDANCE_LO];
    wire [6:0] gainCode  = analogGain[`POS_GAIN_HI:`POS_GAIN_LO];
    wire       gainNeg   = analogGain[`POS_GAIN_NEGATIVE];
    wire       analogSel = (source == `SRC_DIFFERENTIAL) || (source == `SRC_SINGLE_ENDED);

    // ----------------------------------------
    // decode flops
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sourceAnalog        <= 1'b1;
            sourcePulseMic      <= 1'b0;
            sourceReserved      <= 1'b0;
            couplingDcActive    <= 1'b0;
            impedanceReserved   <= 1'b0;
            enhancerActive      <= 1'b0;
            levelControlActive  <= 1'b0;
            gainHalfDb          <= 8'sh00;
            gainCodeReserved    <= 1'b0;
            negativeGainIllegal <= 1'b0;
            volumeMute          <= 1'b0;
            volumeHalfDb        <= 9'sh000;
            trimTenthDb         <= 5'sh00;
        end else begin
            sourceAnalog        <= analogSel;
            sourcePulseMic      <= (source == `SRC_PULSE_MIC);
            sourceReserved      <= (source == `SRC_RESERVED);
            couplingDcActive    <= inputSetup[`POS_COUPLING] & analogSel;
            impedanceReserved   <= (impedance == `IMP_RESERVED);
            enhancerActive      <= inputSetup[`POS_RANGE_ENABLE] & ~rangeModeSelect;
            levelControlActive  <= inputSetup[`POS_RANGE_ENABLE] & rangeModeSelect;
            gainHalfDb          <= gainValue(gainCode, gainNeg);
            gainCodeReserved    <= (gainCode > `GAIN_CODE_MAX);
            negativeGainIllegal <= gainNeg && (impedance == `IMP_2K5);
            volumeMute          <= (digitalVolume == 8'h00);
            volumeHalfDb        <= $signed({1'b0, digitalVolume})
                                   - $signed(`VOLUME_ZERO_DB);
            trimTenthDb         <= $signed({1'b0, gainTrim[`POS_TRIM_HI:`POS_TRIM_LO]})
                                   - $signed(`TRIM_ZERO_DB);
        end
    end

endmodule // chan1_field_decode

// File: design/audio_adc_channel1_config.v
// channel 1 configuration bank with its two-wire control port
// assumes: scl and sda input sampled on clk_sys, much faster than scl
`timescale 1ns/1ns
`include "chan1_config_defines.vh"

module audio_adc_channel1_config #(
    parameter [6:0] DEVICE_ADDR = `CTRL_DEVICE_ADDR
) (
    input  wire              clk_sys,
    input  wire              rstn,
    input  wire              scl,
    input  wire              sdaIn,
    output wire              sdaOut,
    output reg               sdaOe,
    input  wire              rangeModeSelect,

    output reg               chan1InputKind,
    output reg  [1:0]        chan1InputSource,
    output reg               chan1CouplingSelect,
    output reg  [1:0]        chan1InputImpedance,
    output reg               chan1RangeFunctionEnable,
    output reg  [6:0]        chan1GainCode,
    output reg               chan1GainNegative,
    output reg  [7:0]        chan1VolumeCode,
    output reg  [3:0]        chan1GainTrimCode,

    output wire              sourceAnalog,
    output wire              sourcePulseMic,
    output wire              sourceReserved,
    output wire              couplingDcActive,
    output wire              impedanceReserved,
    output wire              enhancerActive,
    output wire              levelControlActive,
    output wire signed [7:0] gainHalfDb,
    output wire              gainCodeReserved,
    output wire              negativeGainIllegal,
    output wire              volumeMute,
    output wire signed [8:0] volumeHalfDb,
    output wire signed [4:0] trimTenthDb
);

    // ----------------------------------------
    // control port states
    // ----------------------------------------
    localparam [3:0] ST_IDLE     = 4'h0;

    localparam [3:0] ST_ADDR     = 4'h1;
    localparam [3:0] ST_ACK_ADDR = 4'h2;
    localparam [3:0] ST_PTR      = 4'h3;
    localparam [3:0] ST_ACK_PTR  = 4'h4;
    localparam [3:0] ST_WR       = 4'h5;
    localparam [3:0] ST_ACK_WR   = 4'h6;

    localparam [3:0] ST_RD       = 4'h7;
    localparam [3:0] ST_RD_ACK   = 4'h8;
    localparam [3:0] ST_RD_NEXT  = 4'h9;

    reg  [3:0] state;
    reg  [7:0] shift;
    reg  [3:0] bitCount;
    reg        readDir;
    reg  [7:0] pointer;

    reg        sclPrev;
    reg        sdaPrev;

    reg  [7:0] inputSetup;
    reg  [7:0] analogGain;
    reg  [7:0] digitalVolume;
    reg  [7:0] gainTrim;

    reg  [7:0] readData;

    reg        wrStrobe;
    reg  [7:0] wrData;
    reg  [7:0] wrAddr;

    wire sclRise = ~sclPrev & scl;
    wire sclFall = sclPrev & ~scl;

    wire startCond = sclPrev & scl & sdaPrev & ~sdaIn;
    wire stopCond  = sclPrev & scl & ~sdaPrev & sdaIn;

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;

    // ----------------------------------------
    // readback mux, reserved bits masked to zero
    // ----------------------------------------
    always @* begin
        case (pointer)
            `OFS_INPUT_SETUP:    readData = inputSetup & `MASK_INPUT_SETUP;
            `OFS_ANALOG_GAIN:    readData = analogGain;
            `OFS_DIGITAL_VOLUME: readData = digitalVolume;
            `OFS_GAIN_TRIM:      readData = gainTrim & `MASK_GAIN_TRIM;
            default:             readData = 8'h00;
        endcase
    end

    // ----------------------------------------
    // pin history for edge and condition detection
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sdaIn;
        end
    end

    // ----------------------------------------
    // control port engine
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            shift    <= 8'h00;
            bitCount <= 4'h0;
            readDir  <= 1'b0;
            pointer  <= 8'h00;
            sdaOe    <= 1'b0;
            wrStrobe <= 1'b0;
            wrData   <= 8'h00;
            wrAddr   <= 8'h00;
        end else begin
            wrStrobe <= 1'b0;

            if (startCond) begin
                state    <= ST_ADDR;
                bitCount <= 4'h0;
                sdaOe    <= 1'b0;
            end else if (stopCond) begin
                state <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_PTR, ST_WR: begin
                        if (sclRise) begin
                            shift    <= {shift[6:0], sdaIn};
                            bitCount <= bitCount + 4'h1;
                        end else if (sclFall && bitCount == 4'h8) begin
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == DEVICE_ADDR) begin
                                    readDir <= shift[0];
                                    sdaOe   <= 1'b1;
                                    state   <= ST_ACK_ADDR;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_PTR) begin
                                pointer <= shift;
                                sdaOe   <= 1'b1;
                                state   <= ST_ACK_PTR;
                            end else begin
                                wrStrobe <= 1'b1;
                                wrData   <= shift;
                                wrAddr   <= pointer;
                                sdaOe    <= 1'b1;
                                state    <= ST_ACK_WR;
                            end
                        end
                    end

                    ST_ACK_ADDR: begin
                        if (sclFall) begin
                            if (readDir) begin
                                shift    <= readData;
                                sdaOe    <= ~readData[7];
                                bitCount <= 4'h1;
                                state    <= ST_RD;
                            end else begin
                                sdaOe    <= 1'b0;
                                bitCount <= 4'h0;
                                state    <= ST_PTR;
                            end
                        end
                    end

                    ST_ACK_PTR, ST_ACK_WR: begin
                        if (sclFall) begin
                            sdaOe    <= 1'b0;
                            bitCount <= 4'h0;
                            if (state == ST_ACK_WR) begin
                                pointer <= pointer + 8'h01;
                            end
                            state <= ST_WR;
                        end
                    end

                    ST_RD: begin
                        if (sclFall) begin
                            if (bitCount == 4'h8) begin
                                sdaOe   <= 1'b0;
                                pointer <= pointer + 8'h01;
                                state   <= ST_RD_ACK;
                            end else begin
                                shift    <= {shift[6:0], 1'b0};
                                sdaOe    <= ~shift[6];
                                bitCount <= bitCount + 4'h1;
                            end
                        end
                    end

                    ST_RD_ACK: begin
                        if (sclRise) begin
                            state <= sdaIn ? ST_IDLE : ST_RD_NEXT;
                        end
                    end

                    ST_RD_NEXT: begin
                        if (sclFall) begin
                            shift    <= readData;
                            sdaOe    <= ~readData[7];
                            bitCount <= 4'h1;
                            state    <= ST_RD;
                        end
                    end

                    default: begin
                        state <= ST_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inputSetup    <= `RST_INPUT_SETUP;
            analogGain    <= `RST_ANALOG_GAIN;
            digitalVolume <= `RST_DIGITAL_VOLUME;
            gainTrim      <= `RST_GAIN_TRIM;
        end else if (wrStrobe) begin
            case (wrAddr)
                `OFS_INPUT_SETUP:    inputSetup    <= wrData & `MASK_INPUT_SETUP;
                `OFS_ANALOG_GAIN:    analogGain    <= wrData & `MASK_ANALOG_GAIN;
                `OFS_DIGITAL_VOLUME: digitalVolume <= wrData & `MASK_DIGITAL_VOLUME;
                `OFS_GAIN_TRIM:      gainTrim      <= wrData & `MASK_GAIN_TRIM;
                default:             inputSetup    <= inputSetup;
            endcase
        end
    end

    // ----------------------------------------
    // raw field outputs, one flop behind storage
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chan1InputKind           <= 1'b0;
            chan1InputSource         <= `SRC_DIFFERENTIAL;
            chan1CouplingSelect      <= 1'b0;
            chan1InputImpedance      <= `IMP_2K5;
            chan1RangeFunctionEnable <= 1'b0;
            chan1GainCode            <= 7'h00;
            chan1GainNegative        <= 1'b0;
            chan1VolumeCode          <= `RST_DIGITAL_VOLUME;
            chan1GainTrimCode        <= 4'h8;
        end else begin
            chan1InputKind           <= inputSetup[`POS_INPUT_KIND];
            chan1InputSource         <= inputSetup[`POS_SOURCE_HI:`POS_SOURCE_LO];
            chan1CouplingSelect      <= inputSetup[`POS_COUPLING];
            chan1InputImpedance      <= inputSetup[`POS_IMPEDANCE_HI:`POS_IMPEDANCE_LO];
            chan1RangeFunctionEnable <= inputSetup[`POS_RANGE_ENABLE];
            chan1GainCode            <= analogGain[`POS_GAIN_HI:`POS_GAIN_LO];
            chan1GainNegative        <= analogGain[`POS_GAIN_NEGATIVE];
            chan1VolumeCode          <= digitalVolume;
            chan1GainTrimCode        <= gainTrim[`POS_TRIM_HI:`POS_TRIM_LO];
        end
    end

    // ----------------------------------------
    // derived datapath controls
    // ----------------------------------------
    chan1_field_decode u_decode (
        .clk_sys             (clk_sys),
        .rstn                (rstn),
        .inputSetup          (inputSetup),
        .analogGain          (analogGain),
        .digitalVolume       (digitalVolume),
        .gainTrim            (gainTrim),
        .rangeModeSelect     (rangeModeSelect),
        .sourceAnalog        (sourceAnalog),
        .sourcePulseMic      (sourcePulseMic),
        .sourceReserved      (sourceReserved),
        .couplingDcActive    (couplingDcActive),
        .impedanceReserved   (impedanceReserved),
        .enhancerActive      (enhancerActive),
        .levelControlActive  (levelControlActive),
        .gainHalfDb          (gainHalfDb),
        .gainCodeReserved    (gainCodeReserved),
        .negativeGainIllegal (negativeGainIllegal),
        .volumeMute          (volumeMute),
        .volumeHalfDb        (volumeHalfDb),
        .trimTenthDb         (trimTenthDb)
    );

endmodule // audio_adc_channel1_config

// File: tb/ctrl_port_host.sv
// two-wire host model that drives the control port of the channel 1 bank
// assumes: the data wire is open drain with a pull-up, resolved here
`timescale 1ns/1ns
module ctrl_port_host (
    input  wire clk_sys,
    input  wire sdaOe,
    output reg  scl,
    output wire sdaIn
);
    reg sdaLow;
    // ----------------------------------------
    // wire level and bus phases
    // ----------------------------------------
    assign sdaIn = ~(sdaLow | sdaOe);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // four clocks per bus phase, above the three-clock minimum
    task automatic phase;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic start_cond;
        sdaLow <= 1'b0;
        phase;
        scl <= 1'b1;
        phase;
        sdaLow <= 1'b1;
        phase;
        scl <= 1'b0;
        phase;
    endtask
    task automatic stop_cond;
        sdaLow <= 1'b1;
        phase;
        scl <= 1'b1;
        phase;
        sdaLow <= 1'b0;
        phase;
    endtask
    task automatic put_bit(input logic v);
        sdaLow <= ~v;
        phase;
        scl <= 1'b1;
        phase;
        scl <= 1'b0;
        phase;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        sdaLow <= 1'b0;
        phase;
        scl <= 1'b1;
        phase;
        ack = ~sdaIn;
        scl <= 1'b0;
        phase;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        sdaLow <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            scl <= 1'b1;
            phase;
            b[i] = sdaIn;
            scl <= 1'b0;
            phase;
        end
        put_bit(last);
    endtask
endmodule // ctrl_port_host

// File: tb/chan1_config_chk_sva.sv
// checker: decoded controls follow the stored channel 1 fields
// assumes: bound into audio_adc_channel1_config, single clock domain
`timescale 1ns/1ns
module chan1_config_chk (
    input wire              clk_sys,
    input wire              rstn,
    input wire              rangeModeSelect,
    input wire [1:0]        chan1InputSource,
    input wire              chan1CouplingSelect,
    input wire [1:0]        chan1InputImpedance,
    input wire              chan1RangeFunctionEnable,
    input wire [6:0]        chan1GainCode,
    input wire              chan1GainNegative,
    input wire [7:0]        chan1VolumeCode,
    input wire [3:0]        chan1GainTrimCode,
    input wire              sourceAnalog,
    input wire              sourcePulseMic,
    input wire              couplingDcActive,
    input wire              impedanceReserved,
    input wire              enhancerActive,
    input wire signed [7:0] gainHalfDb,
    input wire              negativeGainIllegal,
    input wire              volumeMute,
    input wire signed [8:0] volumeHalfDb,
    input wire signed [4:0] trimTenthDb
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_pulse_source: assert property (sourcePulseMic == (chan1InputSource == 2'h2))
        else $error("pulse source flag wrong");
    a_analog_source: assert property (sourceAnalog == !chan1InputSource[1])
        else $error("analog source flag wrong");
    a_dc_gated: assert property (couplingDcActive == (chan1CouplingSelect & sourceAnalog))
        else $error("dc coupling not gated by source");
    a_imp_reserved: assert property (impedanceReserved == (chan1InputImpedance == 2'h3))
        else $error("impedance reserved flag wrong");
    a_range_select: assert property ($stable(rangeModeSelect) |->
        enhancerActive == (chan1RangeFunctionEnable & ~rangeModeSelect))
        else $error("enhancer enable wrong");
    a_gain_pos: assert property (!chan1GainNegative |-> gainHalfDb ==
        ((chan1GainCode > 7'h54) ? 8'h54 : {1'b0, chan1GainCode}))
        else $error("positive gain wrong");
    a_gain_neg: assert property (chan1GainNegative |-> gainHalfDb ==
        (8'h00 - ((chan1GainCode > 7'h16) ? 8'h16 : {1'b0, chan1GainCode})))
        else $error("negative gain wrong");
    a_neg_illegal: assert property (negativeGainIllegal ==
        (chan1GainNegative && chan1InputImpedance == 2'h0))
        else $error("negative gain check wrong");
    a_volume_mute: assert property (volumeMute == (chan1VolumeCode == 8'h00))
        else $error("mute flag wrong");
    a_volume_map: assert property (volumeHalfDb == ({1'b0, chan1VolumeCode} - 9'h0c9))
        else $error("volume step wrong");
    a_trim_map: assert property (trimTenthDb == ({1'b0, chan1GainTrimCode} - 5'h08))
        else $error("trim step wrong");
endmodule // chan1_config_chk
bind audio_adc_channel1_config chan1_config_chk i_chk (.*);

// File: tb/tb_audio_adc_channel1_config.sv
// testbench: register accesses over the control port, then output checks
// assumes: ctrl_port_host model, checker bound into the design
`timescale 1ns/1ns
`include "chan1_config_defines.vh"
module tb_audio_adc_channel1_config;
    reg               clk_sys = 1'b0;
    reg               rstn = 1'b0;
    reg               rangeModeSelect = 1'b0;
    wire              scl, sdaIn, sdaOut, sdaOe;
    wire              chan1InputKind, chan1CouplingSelect, chan1RangeFunctionEnable;
    wire [1:0]        chan1InputSource, chan1InputImpedance;
    wire [6:0]        chan1GainCode;
    wire              chan1GainNegative;
    wire [7:0]        chan1VolumeCode;
    wire [3:0]        chan1GainTrimCode;
    wire              sourceAnalog, sourcePulseMic, sourceReserved, couplingDcActive;
    wire              impedanceReserved, enhancerActive, levelControlActive;
    wire              gainCodeReserved, negativeGainIllegal, volumeMute;
    wire signed [7:0] gainHalfDb;
    wire signed [8:0] volumeHalfDb;
    wire signed [4:0] trimTenthDb;
    int               n_errors = 0;
    int               n_checks = 0;
    int               cycles = 0;
    logic [7:0]       d;
    logic             a;
    audio_adc_channel1_config i_dut (.*);
    ctrl_port_host host (.clk_sys(clk_sys), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));
    always #20 clk_sys = ~clk_sys;
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
        logic a0, a1, a2;
        host.start_cond;
        host.put_byte({`CTRL_DEVICE_ADDR, 1'b0}, a0);
        host.put_byte(ptr, a1);
        host.put_byte(v, a2);
        host.stop_cond;
        @(negedge clk_sys);
        check("write ack", {6'h00, a0, a1, a2}, 9'h007);
    endtask
    task automatic rc(input logic [7:0] ptr, input logic [7:0] exp);
        logic a0, a1, a2;
        logic [7:0] v;
        host.start_cond;
        host.put_byte({`CTRL_DEVICE_ADDR, 1'b0}, a0);
        host.put_byte(ptr, a1);
        host.start_cond;
        host.put_byte({`CTRL_DEVICE_ADDR, 1'b1}, a2);
        host.get_byte(1'b1, v);
        host.stop_cond;
        @(negedge clk_sys);
        check("read ack", {6'h00, a0, a1, a2}, 9'h007);
        check("read data", {1'b0, v}, {1'b0, exp});
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            give_verdict;
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] rv[4] = '{8'h00, 8'h00, 8'hc9, 8'h80};
        logic [7:0] gw[6] = '{8'h02, 8'ha8, 8'haa, 8'h2d, 8'h2f, 8'h15};
        logic [8:0] ge[6] = '{9'h001, 9'h054, 9'h154, 9'h0ea, 9'h0ea, 9'h0f6};
        logic [7:0] vw[4] = '{8'h00, 8'h01, 8'hc9, 8'hff};
        logic [8:0] ve[4] = '{9'h137, 9'h138, 9'h000, 9'h036};
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check("reset flags", {4'h0, sdaOe, sdaOut, enhancerActive, levelControlActive,
            sourceAnalog}, 9'h001);
        check("reset volume", volumeHalfDb, 9'h000);
        for (int i = 0; i < 4; i++) rc(8'h3c + i[7:0], rv[i]);
        wr(8'h3c, 8'hff);
        rc(8'h3c, 8'hfd);
        check("setup flags", {4'h0, chan1InputKind, sourceReserved, couplingDcActive,
            impedanceReserved, chan1RangeFunctionEnable}, 9'h01b);
        for (int s = 0; s < 3; s++) begin
            rangeModeSelect <= s[0];
            // source 2 assumes the host has set the pulse mic pins elsewhere
            wr(8'h3c, {1'b0, s[1:0], 5'b10101});
            check("source flags", {4'h0, sourceAnalog, sourcePulseMic, couplingDcActive,
                enhancerActive, levelControlActive},
                {4'h0, s != 2, s == 2, s != 2, ~s[0], s[0]});
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'h3d, gw[i]);
            check("gain", {gainCodeReserved, gainHalfDb}, ge[i]);
        end
        wr(8'h3c, 8'h00);
        check("negative gain illegal", {8'h00, negativeGainIllegal}, 9'h001);
        for (int i = 0; i < 4; i++) begin
            wr(8'h3e, vw[i]);
            check("volume", volumeHalfDb, ve[i]);
            check("mute", {8'h00, volumeMute}, {8'h00, i == 0});
        end
        wr(8'h3f, 8'hff);
        rc(8'h3f, 8'hf0);
        check("trim", {4'h0, trimTenthDb}, 9'h007);
        wr(8'h3f, 8'h0f);
        rc(8'h3f, 8'h00);
        check("trim", {4'h0, trimTenthDb}, 9'h018);
        wr(8'h50, 8'ha5);
        rc(8'h50, 8'h00);
        host.start_cond;
        host.put_byte({`CTRL_DEVICE_ADDR ^ 7'h01, 1'b0}, a);
        host.stop_cond;
        check("foreign address ack", {8'h00, a}, 9'h000);
        give_verdict;
    end
endmodule // tb_audio_adc_channel1_config
